//--- rtl/iaclm_matcher.v
// How it works
// - Entry pointer picks action zero to fifteen
// - Sixteen-bit mask selects rules, ANDed
// - Lowest true action pointer wins
// - Shared action pointer ORs entry results
// - Layer select zero disables the rule
// - Layer 2 options: count, MAC, type, both
// - Layer 3: masked address or both unmasked
// - Layer 4: protocol, TCP, UDP, sequence
// - Address select: zero destination, one source
// - Polarity zero mismatch true, one equal
// - Count value from five action fields
// - Count rule uses same-index action, no forwarding
// - Tick scale: microsecond or millisecond
// - Timer mode counts down, interrupts on expiry
// - Event mode counts up, interrupts, resets
// - Sixteen ordered entries, entry zero first
// - Map mode keeps, ORs, ANDs or replaces
`include "iaclm_regs.vh"
`timescale 1ns/1ns
`default_nettype none
module iaclm_matcher (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output reg pslverr,
  output wire irq,
  input wire pkt_valid,
  output wire pkt_ready,
  input wire [47:0] pkt_dst_mac,
  input wire [47:0] pkt_src_mac,
  input wire [15:0] pkt_ethertype,
  input wire pkt_is_ipv4,
  input wire [31:0] pkt_src_ip,
  input wire [31:0] pkt_dst_ip,
  input wire [7:0] pkt_ip_proto,
  input wire pkt_is_tcp,
  input wire pkt_is_udp,
  input wire [15:0] pkt_src_port,
  input wire [15:0] pkt_dst_port,
  input wire [31:0] pkt_tcp_seq,
  input wire [6:0] pkt_fwd_map,
  output reg res_valid,
  output reg res_hit,
  output reg [3:0] res_action,
  output reg [6:0] res_fwd_map,
  output reg [1:0] res_prio_mode,
  output reg [2:0] res_prio,
  output reg res_remark_en,
  output reg [2:0] res_remark_level
);
  localparam ST_IDLE = 2'd0;
  localparam ST_SCAN = 2'd1;
  localparam ST_RES = 2'd2;
  localparam integer US_N = `IACLM_US_CYC - 1;
  localparam integer MS_N = `IACLM_MS_US - 1;
  localparam [4:0] US_LAST = US_N[4:0];
  localparam [9:0] MS_LAST = MS_N[9:0];

  reg [3:0] ptr_q [0:15];
  reg [15:0] sel_q [0:15];
  reg [19:0] act_q [0:15];
  reg [31:0] rule_lo_q;
  reg [31:0] rule_hi_q;
  reg [15:0] count_mode_q;
  reg [15:0] int_stat_q;
  reg [15:0] int_en_q;
  reg ctrl_en_q;
  reg [1:0] st_q;
  reg [4:0] cnt_q;
  reg [15:0] match_q;
  reg [15:0] cnt_hit_q;
  reg [4:0] us_q;
  reg [9:0] ms_q;
  reg tick_us_q;
  reg tick_ms_q;
  reg [47:0] dmac_q;
  reg [47:0] smac_q;
  reg [15:0] etype_q;
  reg ipv4_q;
  reg [31:0] sip_q;
  reg [31:0] dip_q;
  reg [7:0] proto_q;
  reg tcp_q;
  reg udp_q;
  reg [15:0] sport_q;
  reg [15:0] dport_q;
  reg [31:0] seq_q;
  reg [6:0] map_q;
  wire [69:0] rule;
  wire [15:0] expire;
  integer i;
  // Own loop variable: the reset loop may not share one with logic
  integer j;

  // APB: zero-wait slave, read data captured in setup phase
  wire setup = psel && !penable;
  wire wr = psel && penable && pwrite;
  wire [1:0] reg_grp = paddr[7:6];
  wire [3:0] reg_idx = paddr[5:2];
  wire addr_ok = (paddr[1:0] == 2'b00) &&
                 (!paddr[7] || paddr <= `IACLM_STATUS);
  assign pready = penable;
  assign irq = |(int_stat_q & int_en_q);
  assign pkt_ready = (st_q == ST_IDLE);

  reg [31:0] rd_d;
  always @* begin
    rd_d = 32'h0;
    case (reg_grp)
      `IACLM_PROC_BASE: begin
        rd_d[`IACLM_PROC_PTR] = ptr_q[reg_idx];
        rd_d[`IACLM_PROC_SEL] = sel_q[reg_idx];
      end
      `IACLM_ACT_BASE: rd_d[19:0] = act_q[reg_idx];
      default: begin
        case (paddr)
          `IACLM_RULE_LO: rd_d = rule_lo_q;
          `IACLM_RULE_HI: rd_d = rule_hi_q;
          `IACLM_INT_STAT: rd_d[15:0] = int_stat_q;
          `IACLM_INT_EN: rd_d[15:0] = int_en_q;
          `IACLM_CTRL: rd_d[0] = ctrl_en_q;
          `IACLM_STATUS: rd_d[17:0] = {count_mode_q, res_hit, st_q != ST_IDLE};
          default: rd_d = 32'h0;
        endcase
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else if (ce && setup) begin
      prdata <= rd_d;
      pslverr <= !addr_ok;
    end
  end

  wire commit = wr && addr_ok && paddr == `IACLM_RULE_CTL;
  wire [5:0] ctl_f = pwdata[`IACLM_CTL_FLD];
  wire [3:0] ctl_idx = pwdata[`IACLM_CTL_IDX];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < 16; i = i + 1) begin
        ptr_q[i] <= 4'h0;
        sel_q[i] <= 16'h0;
        act_q[i] <= 20'h0;
      end
      rule_lo_q <= 32'h0;
      rule_hi_q <= 32'h0;
      count_mode_q <= 16'h0;
      int_en_q <= 16'h0;
      ctrl_en_q <= `IACLM_RST_CTRL;
    end else if (ce && wr && addr_ok) begin
      case (reg_grp)
        `IACLM_PROC_BASE: begin
          ptr_q[reg_idx] <= pwdata[`IACLM_PROC_PTR];
          sel_q[reg_idx] <= pwdata[`IACLM_PROC_SEL];
        end
        `IACLM_ACT_BASE: act_q[reg_idx] <= pwdata[19:0];
        default: begin
          case (paddr)
            `IACLM_RULE_LO: rule_lo_q <= pwdata;
            `IACLM_RULE_HI: rule_hi_q <= pwdata;
            `IACLM_RULE_CTL:
              count_mode_q[ctl_idx] <= (ctl_f[3:0] == {2'b00, `IACLM_L_L2});
            `IACLM_INT_EN: int_en_q <= pwdata[15:0];
            `IACLM_CTRL: ctrl_en_q <= pwdata[0];
            default: ctrl_en_q <= ctrl_en_q;
          endcase
        end
      endcase
    end
  end

  // Sticky expiry flags; a same-cycle expiry beats the clear
  wire clr_wr = wr && paddr == `IACLM_INT_CLR;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat_q <= 16'h0;
    end else if (ce) begin
      int_stat_q <= (int_stat_q & ~(clr_wr ? pwdata[15:0] : 16'h0)) | expire;
    end
  end

  // Shared time base: one microsecond and one millisecond pulse
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      us_q <= 5'h0;
      ms_q <= 10'h0;
      tick_us_q <= 1'b0;
      tick_ms_q <= 1'b0;
    end else if (ce) begin
      tick_us_q <= (us_q == US_LAST);
      tick_ms_q <= (us_q == US_LAST) && (ms_q == MS_LAST);
      if (us_q == US_LAST) begin
        us_q <= 5'h0;
        ms_q <= (ms_q == MS_LAST) ? 10'h0 : ms_q + 10'h1;
      end else begin
        us_q <= us_q + 5'h1;
      end
    end
  end

  iaclm_rule_mem u_mem (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .we(commit),
    .waddr(ctl_idx),
    .wdata({ctl_f, rule_hi_q, rule_lo_q}),
    .raddr(cnt_q[3:0]),
    .rdata(rule)
  );

  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1) begin : g_cnt
      iaclm_count_unit u_cnt (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .en(count_mode_q[g]),
        .algo(act_q[g][`IACLM_ACT_CA]),
        .scale(act_q[g][`IACLM_ACT_TS]),
        .value(act_q[g][`IACLM_ACT_CNT]),
        .tick_us(tick_us_q),
        .tick_ms(tick_ms_q),
        .hit(cnt_hit_q[g]),
        .expire(expire[g])
      );
    end
  endgenerate

  // Rule evaluation on the word read out last cycle
  wire [1:0] r_layer = rule[65:64];
  wire [1:0] r_opt = rule[67:66];
  wire r_src = rule[68];
  wire r_pol = rule[69];
  wire [63:0] r_dat = rule[63:0];
  wire [47:0] pk_mac = r_src ? smac_q : dmac_q;
  wire [31:0] pk_ip = r_src ? sip_q : dip_q;
  wire [15:0] pk_port = r_src ? sport_q : dport_q;
  wire mac_eq = (pk_mac == r_dat[47:0]);
  wire type_eq = (etype_q == r_dat[63:48]);
  wire port_eq = (pk_port == r_dat[15:0]) || (pk_port == r_dat[31:16]);
  reg eq;
  reg valid_cmp;

  always @* begin
    eq = 1'b0;
    valid_cmp = 1'b1;
    case (r_layer)
      `IACLM_L_L2: begin
        case (r_opt)
          2'b01: eq = mac_eq;
          2'b10: eq = type_eq;
          default: eq = mac_eq && type_eq;
        endcase
        valid_cmp = (r_opt != 2'b00);
      end
      `IACLM_L_L3: begin
        case (r_opt)
          2'b01: eq = ipv4_q && (((pk_ip ^ r_dat[31:0]) & ~r_dat[63:32]) == 32'h0);
          2'b10: eq = ipv4_q && sip_q == r_dat[31:0] && dip_q == r_dat[63:32];
          default: valid_cmp = 1'b0;
        endcase
      end
      `IACLM_L_L4: begin
        case (r_opt)
          2'b00: eq = ipv4_q && proto_q == r_dat[7:0];
          2'b01: eq = tcp_q && port_eq;
          2'b10: eq = udp_q && port_eq;
          default: eq = tcp_q && seq_q == r_dat[31:0];
        endcase
      end
      default: valid_cmp = 1'b0;
    endcase
  end

  wire rule_true = valid_cmp && (r_pol ? eq : !eq);
  wire cnt_qual = (r_layer == `IACLM_L_L2) && (r_opt == 2'b00) && mac_eq && type_eq;
  wire [3:0] eval_idx = cnt_q[3:0] - 4'h1;

  // Resolution: per-action OR of entry results, lowest pointer wins
  reg [15:0] act_hit;
  reg [3:0] win;
  reg any;
  always @* begin
    act_hit = 16'h0;
    for (j = 0; j < 16; j = j + 1) begin
      if (sel_q[j] != 16'h0 && (sel_q[j] & ~match_q) == 16'h0) begin
        act_hit[ptr_q[j]] = 1'b1;
      end
    end
    act_hit = act_hit & ~count_mode_q;
    win = 4'h0;
    any = 1'b0;
    for (j = 15; j >= 0; j = j - 1) begin
      if (act_hit[j]) begin
        win = j[3:0];
        any = 1'b1;
      end
    end
  end

  wire [19:0] wact = act_q[win];
  reg [6:0] map_d;
  always @* begin
    case (wact[`IACLM_ACT_MM])
      2'b00: map_d = map_q;
      2'b01: map_d = map_q | wact[`IACLM_ACT_FWD];
      2'b10: map_d = map_q & wact[`IACLM_ACT_FWD];
      default: map_d = wact[`IACLM_ACT_FWD];
    endcase
  end
  wire take = any && ctrl_en_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ST_IDLE;
      cnt_q <= 5'h0;
      match_q <= 16'h0;
      cnt_hit_q <= 16'h0;
      res_valid <= 1'b0;
      res_hit <= 1'b0;
      res_action <= 4'h0;
      res_fwd_map <= 7'h0;
      res_prio_mode <= 2'b00;
      res_prio <= 3'h0;
      res_remark_en <= 1'b0;
      res_remark_level <= 3'h0;
      dmac_q <= 48'h0;
      smac_q <= 48'h0;
      etype_q <= 16'h0;
      ipv4_q <= 1'b0;
      sip_q <= 32'h0;
      dip_q <= 32'h0;
      proto_q <= 8'h0;
      tcp_q <= 1'b0;
      udp_q <= 1'b0;
      sport_q <= 16'h0;
      dport_q <= 16'h0;
      seq_q <= 32'h0;
      map_q <= 7'h0;
    end else if (ce) begin
      res_valid <= 1'b0;
      cnt_hit_q <= 16'h0;
      case (st_q)
        ST_IDLE: begin
          cnt_q <= 5'h0;
          if (pkt_valid) begin
            dmac_q <= pkt_dst_mac;
            smac_q <= pkt_src_mac;
            etype_q <= pkt_ethertype;
            ipv4_q <= pkt_is_ipv4;
            sip_q <= pkt_src_ip;
            dip_q <= pkt_dst_ip;
            proto_q <= pkt_ip_proto;
            tcp_q <= pkt_is_tcp;
            udp_q <= pkt_is_udp;
            sport_q <= pkt_src_port;
            dport_q <= pkt_dst_port;
            seq_q <= pkt_tcp_seq;
            map_q <= pkt_fwd_map;
            st_q <= ST_SCAN;
          end
        end
        ST_SCAN: begin
          // Read latency of one: word for entry n arrives at count n+1
          if (cnt_q != 5'h0) begin
            match_q[eval_idx] <= rule_true;
            cnt_hit_q[eval_idx] <= cnt_qual;
          end
          if (cnt_q == 5'h10) begin
            st_q <= ST_RES;
          end
          cnt_q <= cnt_q + 5'h1;
        end
        ST_RES: begin
          res_valid <= 1'b1;
          res_hit <= take;
          res_action <= take ? win : 4'h0;
          res_fwd_map <= take ? map_d : map_q;
          res_prio_mode <= take ? wact[`IACLM_ACT_PM] : 2'b00;
          res_prio <= take ? wact[`IACLM_ACT_P] : 3'h0;
          res_remark_en <= take && wact[`IACLM_ACT_RPE];
          res_remark_level <= take ? wact[`IACLM_ACT_RP] : 3'h0;
          st_q <= ST_IDLE;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end
endmodule // iaclm_matcher
`default_nettype wire

//--- rtl/iaclm_regs.vh
`ifndef IACLM_REGS_VH
`define IACLM_REGS_VH
`define IACLM_PROC_BASE 2'b00
`define IACLM_ACT_BASE 2'b01
`define IACLM_RULE_LO 8'h80
`define IACLM_RULE_HI 8'h84
`define IACLM_RULE_CTL 8'h88
`define IACLM_INT_STAT 8'h8c
`define IACLM_INT_CLR 8'h90
`define IACLM_INT_EN 8'h94
`define IACLM_CTRL 8'h98
`define IACLM_STATUS 8'h9c
`define IACLM_PROC_PTR 3:0
`define IACLM_PROC_SEL 19:4
`define IACLM_ACT_CNT 10:0
`define IACLM_ACT_PM 10:9
`define IACLM_ACT_P 8:6
`define IACLM_ACT_RPE 5
`define IACLM_ACT_RP 4:2
`define IACLM_ACT_MM 1:0
`define IACLM_ACT_FWD 17:11
`define IACLM_ACT_TS 18
`define IACLM_ACT_CA 19
`define IACLM_CTL_IDX 11:8
`define IACLM_CTL_FLD 5:0
`define IACLM_RST_CTRL 1'b1
`define IACLM_CLK_NS 50
`define IACLM_US_NS 1000
`define IACLM_US_CYC ((`IACLM_US_NS + `IACLM_CLK_NS - 1) / `IACLM_CLK_NS)
`define IACLM_MS_US 1000
`define IACLM_L_OFF 2'b00
`define IACLM_L_L2 2'b01
`define IACLM_L_L3 2'b10
`define IACLM_L_L4 2'b11
`endif

//--- rtl/iaclm_rule_mem.v
`timescale 1ns/1ns
`default_nettype none
module iaclm_rule_mem (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire we,
  input wire [3:0] waddr,
  input wire [69:0] wdata,
  input wire [3:0] raddr,
  output reg [69:0] rdata
);
  reg [69:0] mem [0:15];

  always @(posedge pclk) begin
    if (ce && we) begin
      mem[waddr] <= wdata;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata <= 70'h0;
    end else if (ce) begin
      rdata <= mem[raddr];
    end
  end
endmodule // iaclm_rule_mem
`default_nettype wire

//--- rtl/iaclm_count_unit.v
`timescale 1ns/1ns
`default_nettype none
module iaclm_count_unit (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire en,
  input wire algo,
  input wire scale,
  input wire [10:0] value,
  input wire tick_us,
  input wire tick_ms,
  input wire hit,
  output reg expire
);
  reg [10:0] cnt_q;
  reg armed_q;
  wire tick = scale ? tick_ms : tick_us;
  wire [10:0] inc = cnt_q + 11'h1;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 11'h0;
      armed_q <= 1'b0;
      expire <= 1'b0;
    end else if (ce) begin
      expire <= 1'b0;
      if (!en) begin
        cnt_q <= 11'h0;
        armed_q <= 1'b0;
      end else if (algo) begin
        if (hit && inc == value) begin
          cnt_q <= 11'h0;
          expire <= 1'b1;
        end else if (hit) begin
          cnt_q <= inc;
        end
      end else if (hit) begin
        cnt_q <= value;
        armed_q <= 1'b1;
      end else if (armed_q && tick) begin
        if (cnt_q <= 11'h1) begin
          cnt_q <= 11'h0;
          armed_q <= 1'b0;
          expire <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 11'h1;
        end
      end
    end
  end
endmodule // iaclm_count_unit
`default_nettype wire

//--- sim/iaclm_matcher_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module iaclm_matcher_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq,
  input wire logic pkt_valid,
  input wire logic pkt_ready,
  input wire logic [6:0] pkt_fwd_map,
  input wire logic res_valid,
  input wire logic res_hit,
  input wire logic [3:0] res_action,
  input wire logic [6:0] res_fwd_map
);
  logic [6:0] map_q;
  // Lookup map of the packet in flight; no new take until the result is out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) map_q <= 7'h00;
    else if (pkt_valid && pkt_ready && ce) map_q <= pkt_fwd_map;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_take; pkt_valid && pkt_ready && ce; endsequence
  sequence s_wr; psel && penable && pwrite; endsequence
  sequence s_setup; psel && !penable; endsequence
  property p_take_busy; s_take |=> !pkt_ready [*8]; endproperty
  a_take_busy: assert property (p_take_busy) else $error("ready during scan");
  property p_answer; s_take |-> ##[17:20] res_valid; endproperty
  a_answer: assert property (p_answer) else $error("no result in time");
  property p_one_result; res_valid |=> !res_valid; endproperty
  a_one_result: assert property (p_one_result) else $error("result pulse too long");
  property p_hold; !res_valid |-> $stable(res_action) && $stable(res_hit); endproperty
  a_hold: assert property (p_hold) else $error("result changed between pulses");
  property p_miss; res_valid && !res_hit |-> res_fwd_map == map_q && res_action == 4'h0;
  endproperty
  a_miss: assert property (p_miss) else $error("miss altered the map");
  property p_ready_back; res_valid |-> pkt_ready; endproperty
  a_ready_back: assert property (p_ready_back) else $error("not idle at result");
  property p_irq_hold; irq && !(psel && penable && pwrite) |=> irq; endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("interrupt fell unasked");
  property p_zero_wait; psel && penable |-> pready; endproperty
  a_zero_wait: assert property (p_zero_wait) else $error("access phase stalled");
  property p_align; s_setup ##1 (penable && paddr[1:0] != 2'b00) |-> pslverr; endproperty
  a_align: assert property (p_align) else $error("misaligned access accepted");
endmodule // iaclm_matcher_asserts
bind iaclm_matcher iaclm_matcher_asserts iaclm_matcher_asserts_i (.pclk(pclk), .presetn(presetn),
  .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready),
  .pslverr(pslverr), .irq(irq), .pkt_valid(pkt_valid), .pkt_ready(pkt_ready),
  .pkt_fwd_map(pkt_fwd_map), .res_valid(res_valid), .res_hit(res_hit),
  .res_action(res_action), .res_fwd_map(res_fwd_map));
`default_nettype wire

//--- sim/iaclm_matcher_test.sv
`timescale 1ns/1ns
`default_nettype none
module iaclm_matcher_test;
  localparam logic [47:0] M1 = 48'h0200_0000_0001;
  localparam logic [47:0] MX = 48'h0200_0000_00aa;
  localparam logic [47:0] MN = 48'h0200_0000_0f0f;
  localparam logic [47:0] M2 = 48'h0200_0000_0c02;
  localparam logic [47:0] M3 = 48'h0200_0000_0c03;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, irq, pkt_ready, res_valid, res_hit, res_remark_en;
  logic pkt_valid = 1'b0, pkt_is_ipv4 = 1'b0, pkt_is_tcp = 1'b0, pkt_is_udp = 1'b0;
  logic [47:0] pkt_dst_mac = 48'h0, pkt_src_mac = 48'h0;
  logic [15:0] pkt_ethertype = 16'h0, pkt_src_port = 16'h0, pkt_dst_port = 16'h0;
  logic [31:0] pkt_src_ip = 32'h0, pkt_dst_ip = 32'h0, pkt_tcp_seq = 32'h0;
  logic [7:0] pkt_ip_proto = 8'h00;
  logic [6:0] pkt_fwd_map = 7'h30, res_fwd_map;
  logic [3:0] res_action;
  logic [1:0] res_prio_mode;
  logic [2:0] res_prio, res_remark_level;
  logic [31:0] rdat;
  logic rerr;
  int fail_count = 0;
  int total_checks = 0;
  iaclm_matcher iaclm_matcher_i (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .irq, .pkt_valid, .pkt_ready, .pkt_dst_mac,
    .pkt_src_mac, .pkt_ethertype, .pkt_is_ipv4, .pkt_src_ip, .pkt_dst_ip, .pkt_ip_proto,
    .pkt_is_tcp, .pkt_is_udp, .pkt_src_port, .pkt_dst_port, .pkt_tcp_seq, .pkt_fwd_map,
    .res_valid, .res_hit, .res_action, .res_fwd_map, .res_prio_mode, .res_prio,
    .res_remark_en, .res_remark_level);
  always #25 pclk = ~pclk;
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    apb(1'b0, a, 32'h0);
    chk(n, e, rdat);
  endtask
  task automatic rule(input logic [3:0] i, input logic [63:0] d, input logic [5:0] f);
    apb(1'b1, 8'h80, d[31:0]);
    apb(1'b1, 8'h84, d[63:32]);
    apb(1'b1, 8'h88, {20'h0, i, 2'b00, f});
  endtask
  task automatic proc(input logic [3:0] i, input logic [3:0] p, input logic [15:0] m);
    apb(1'b1, {2'b00, i, 2'b00}, {12'h0, m, p});
  endtask
  task automatic act(input logic [3:0] i, input logic [31:0] v);
    apb(1'b1, {2'b01, i, 2'b00}, v);
  endtask
  task automatic pkt(input logic [47:0] dm, input logic [47:0] sm, input logic [15:0] et,
      input logic [31:0] ip, input logic [7:0] pr);
    int n;
    n = 0;
    @(posedge pclk);
    pkt_dst_mac <= dm;
    pkt_src_mac <= sm;
    pkt_ethertype <= et;
    pkt_is_ipv4 <= (ip != 32'h0);
    pkt_dst_ip <= ip;
    pkt_src_ip <= ~ip;
    pkt_ip_proto <= pr;
    pkt_is_tcp <= (pr == 8'h06);
    pkt_is_udp <= (pr == 8'h11);
    pkt_src_port <= ip[15:0];
    pkt_dst_port <= ip[31:16];
    pkt_tcp_seq <= ip;
    pkt_valid <= 1'b1;
    do @(posedge pclk); while (pkt_ready !== 1'b1 && ++n < 40);
    pkt_valid <= 1'b0;
    do @(posedge pclk); while (res_valid !== 1'b1 && ++n < 80);
    if (n >= 80) chk("res_valid", 32'h1, 32'h0);
  endtask
  task automatic res(input logic h, input logic [3:0] a, input logic [6:0] f);
    chk("result", {20'h0, h, a, f}, {20'h0, res_hit, res_action, res_fwd_map});
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h98, 32'h1, "ctrl");
    rd(8'h8c, 32'h0, "int_stat");
    apb(1'b0, 8'h02, 32'h0);
    chk("pslverr", 32'h1, {31'h0, rerr});
    // Rule memory has no reset value
    for (int i = 0; i < 16; i++) rule(i[3:0], 64'h0, 6'h00);
    rule(4'd0, {16'h0, M1}, 6'h25);
    rule(4'd1, {16'h0800, 48'h0}, 6'h29);
    rule(4'd2, {16'h0, M1}, 6'h24);
    rule(4'd3, {16'h0, MX}, 6'h35);
    rule(4'd4, {16'h0800, 48'h0}, 6'h09);
    rule(4'd5, {56'h0, 8'h11}, 6'h23);
    rule(4'd6, {32'h00ff_ffff, 32'h0a00_0000}, 6'h26);
    rule(4'd7, {16'h88b5, M2}, 6'h01);
    rule(4'd8, {16'h88b5, M3}, 6'h01);
    proc(4'd0, 4'd5, 16'h0001);
    proc(4'd1, 4'd1, 16'h0004);
    proc(4'd2, 4'd3, 16'h0003);
    proc(4'd3, 4'd5, 16'h0008);
    proc(4'd4, 4'd10, 16'h0010);
    proc(4'd5, 4'd9, 16'h0020);
    proc(4'd6, 4'd11, 16'h0040);
    proc(4'd7, 4'd7, 16'h0080);
    act(4'd3, 32'h0002_af6f);
    act(4'd5, 32'h0000_7801);
    act(4'd9, 32'h0000_0803);
    act(4'd10, 32'h0000_7802);
    act(4'd11, 32'h0000_7800);
    act(4'd7, 32'h0008_0003);
    act(4'd8, 32'h0000_0004);
    pkt(M1, MN, 16'h0800, 32'h0, 8'h00);
    res(1'b1, 4'h3, 7'h55);
    chk("prio", 32'h1db, {23'h0, res_prio_mode, res_prio, res_remark_en, res_remark_level});
    pkt(M1, MN, 16'h0801, 32'h0, 8'h00);
    res(1'b1, 4'h5, 7'h3f);
    pkt(MN, MN, 16'h0800, 32'h0, 8'h00);
    res(1'b0, 4'h0, 7'h30);
    pkt(MN, MX, 16'h0800, 32'h0, 8'h00);
    res(1'b1, 4'h5, 7'h3f);
    pkt(MN, MN, 16'h86dd, 32'h0, 8'h00);
    res(1'b1, 4'ha, 7'h00);
    pkt(MN, MN, 16'h0800, 32'h0b00_0001, 8'h11);
    res(1'b1, 4'h9, 7'h01);
    pkt(MN, MN, 16'h0800, 32'h0a12_3456, 8'h06);
    res(1'b1, 4'hb, 7'h30);
    apb(1'b1, 8'h94, 32'h0000_0180);
    for (int k = 0; k < 2; k++) begin
      pkt(M2, MN, 16'h88b5, 32'h0, 8'h00);
      res(1'b1, 4'ha, 7'h00);
      pkt(M2, MN, 16'h88b5, 32'h0, 8'h00);
      rd(8'h8c, 32'h0, "int_stat");
      pkt(M2, MN, 16'h88b5, 32'h0, 8'h00);
      rd(8'h8c, 32'h80, "int_stat");
      chk("irq", 32'h1, {31'h0, irq});
      apb(1'b1, 8'h94, 32'h0000_0100);
      // Enable write lands at the access edge; look once it has settled
      @(negedge pclk);
      chk("irq", 32'h0, {31'h0, irq});
      apb(1'b1, 8'h94, 32'h0000_0180);
      apb(1'b1, 8'h90, 32'h0000_0080);
      rd(8'h8c, 32'h0, "int_stat");
      chk("irq", 32'h0, {31'h0, irq});
    end
    // Second packet must restart the countdown before the first load runs out
    pkt(M3, MN, 16'h88b5, 32'h0, 8'h00);
    repeat (30) @(posedge pclk);
    pkt(M3, MN, 16'h88b5, 32'h0, 8'h00);
    repeat (30) @(posedge pclk);
    rd(8'h8c, 32'h0, "int_stat");
    repeat (60) @(posedge pclk);
    rd(8'h8c, 32'h100, "int_stat");
    chk("irq", 32'h1, {31'h0, irq});
    // Global enable off: a matching packet takes no action
    apb(1'b1, 8'h98, 32'h0);
    pkt(M1, MN, 16'h0800, 32'h0, 8'h00);
    res(1'b0, 4'h0, 7'h30);
    rd(8'h9c, 32'h600, "status");
    apb(1'b1, 8'h98, 32'h1);
    rd(8'h94, 32'h180, "int_en");
    rd(8'h08, 32'h33, "proc2");
    rd(8'h4c, 32'h2af6f, "act3");
    // Millisecond scale: a load of two cannot expire within the first tick
    apb(1'b1, 8'h90, 32'h0000_0100);
    act(4'd8, 32'h0004_0002);
    pkt(M3, MN, 16'h88b5, 32'h0, 8'h00);
    repeat (200) @(posedge pclk);
    rd(8'h8c, 32'h0, "int_stat");
    repeat (40100) @(posedge pclk);
    rd(8'h8c, 32'h100, "int_stat");
    summarize();
  end
  initial begin
    repeat (60000) @(posedge pclk);
    fail_count++;
    summarize();
  end
endmodule // iaclm_matcher_test
`default_nettype wire
